// ===== include/timer_capture_pkg.sv
/*
  Constants, register indices, field positions and the edge decode shared by the
  input-capture timer and its input conditioner.
  Assumes a 20 MHz timer operation clock and an AHB-Lite bus with 32-bit data.
*/
`default_nettype none
package timer_capture_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 32;
  localparam int CNT_W = 16;
  localparam int NUM_CH = 4;
  localparam int NUM_IN = 8;

  // Register indices; the byte address of each register is four times its index.
  localparam logic [9:0] IDX_MODE = 10'h120;
  localparam logic [9:0] IDX_CTRL1 = 10'h121;
  localparam logic [9:0] IDX_CAP_AB = 10'h124;
  localparam logic [9:0] IDX_CAP_CD = 10'h125;
  localparam logic [9:0] IDX_COUNT = 10'h126;
  localparam logic [9:0] IDX_GRA = 10'h128;
  localparam logic [9:0] IDX_GRB = 10'h129;
  localparam logic [9:0] IDX_GRC = 10'h12a;
  localparam logic [9:0] IDX_GRD = 10'h12b;
  localparam logic [9:0] IDX_FILTER = 10'h12c;
  localparam logic [9:0] IDX_STATUS = 10'h12d;
  localparam logic [9:0] IDX_PORT = 10'h12e;

  // Reset values.
  localparam logic [7:0] RST_CAP_AB = 8'h88;
  localparam logic [7:0] RST_CAP_CD = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_CTRL1 = 8'h00;
  localparam logic [7:0] RST_FILTER = 8'h00;
  localparam logic [7:0] RST_PORT = 8'h00;

  // Field positions.
  localparam int MODE_START = 0;
  localparam int MODE_BUF_C = 5;
  localparam int MODE_BUF_D = 6;
  localparam logic [7:0] MODE_WMASK = 8'h61;
  localparam int CTRL1_CLEAR = 7;
  localparam int CTRL1_SRC_LO = 4;
  localparam int EDGE_LO_LOW = 0;
  localparam int EDGE_HI_LOW = 4;
  localparam int MODE_SEL_LOW = 2;
  localparam int MODE_SEL_HIGH = 6;
  localparam int TRIG_SRC_A = 3;
  localparam logic [7:0] CAP_AB_FIXED = 8'h80;
  localparam int ST_OVF = 4;
  localparam int PORT_DIR_LO = 4;

  // Count source encodings.
  localparam logic [2:0] SRC_DIV1 = 3'h0;
  localparam logic [2:0] SRC_DIV2 = 3'h1;
  localparam logic [2:0] SRC_DIV4 = 3'h2;
  localparam logic [2:0] SRC_DIV8 = 3'h3;
  localparam logic [2:0] SRC_DIV32 = 3'h4;
  localparam logic [2:0] SRC_EXT = 3'h5;
  localparam logic [2:0] SRC_FAST = 3'h6;
  localparam logic [2:0] SRC_FAST_DIV = 3'h7;

  // Edge select encodings.
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  localparam int FILTER_MATCHES = 3;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;

  // Reserved select 11 never produces an event.
  function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
    logic hit;
    hit = 1'b0;
    unique case (sel)
      EDGE_RISE: hit = !prev && cur;
      EDGE_FALL: hit = prev && !cur;
      EDGE_BOTH: hit = prev != cur;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : edge_hit
endpackage : timer_capture_pkg
`default_nettype wire

// ===== design/capture_input_conditioner.sv
/*
  One capture input: two-stage synchroniser, optional three-sample filter and
  edge detector producing one event pulse per qualifying transition.
  Assumes the input may be asynchronous to clk.
*/
`default_nettype none
module capture_input_conditioner (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sig_in,
  input wire logic filter_en,
  input wire logic [1:0] edge_sel,
  output logic evt
);
  import timer_capture_pkg::*;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [FILTER_MATCHES-2:0] hist;
    logic level;
    logic evt;
  } cond_t;

  cond_t st_r;
  cond_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = sig_in;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.hist = {st_r.hist[FILTER_MATCHES-3:0], st_r.sync2};
    // The filter takes a level only after three equal samples in a row.
    if (!filter_en) begin
      st_nxt.level = st_r.sync2;
    end else if (st_r.hist == {(FILTER_MATCHES-1){st_r.sync2}}) begin
      st_nxt.level = st_r.sync2;
    end
    st_nxt.evt = edge_hit(edge_sel, st_r.level, st_nxt.level);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign evt = st_r.evt;

  AST_ONE_EVENT: assert property (@(posedge clk) disable iff (sys_rst)
    st_r.evt |=> !st_r.evt || (st_r.level != $past(st_r.level)))
    else $error("capture event repeated without a new level");
  AST_RISE_EVENT: assert property (@(posedge clk) disable iff (sys_rst)
    !filter_en && edge_sel == EDGE_RISE && st_r.sync2 && !st_r.level |=> st_r.evt)
    else $error("rising input gave no capture event");
endmodule : capture_input_conditioner
`default_nettype wire

// ===== design/timer_input_capture.sv
/*
  Input-capture timer: 16-bit up counter with selectable count source, four
  capture channels with buffering, counter clear on channel A, and an AHB-Lite
  register slave with zero wait states.
  Assumes all pins are conditioned here and one AHB-Lite master drives the bus.
*/
// How it works
// - Valid pin edge copies counter into register.
// - Counter increments, wraps freely when clear off.
// - Clear select clears counter on A capture.
// - Count source is divided clock, oscillator, pin.
// - Writing start bit one starts counting.
// - Writing start bit zero stops, counter held.
// - Captures and overflow raise interrupt requests.
// - Each pin is port or capture input.
// - Counter readable and writable by software.
// - Edge field selects rising, falling or both.
// - Edge fields sit in both capture controls.
// - Trigger source bit picks oscillator or pin.
// - Trigger source matters only in capture mode.
// - First capture control bit seven reads as one.
// - Buffer select makes C/D buffer A/B.
// - First capture control resets to 88h.
// - Buffered capture moves old primary into buffer.
// - Filter accepts level after three matching samples.
// - Buffer channel flag set by own pin.
// - Source codes 101, 110, 111 select external inputs.
`default_nettype none
module timer_input_capture (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [timer_capture_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [timer_capture_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [timer_capture_pkg::DATA_W-1:0] hrdata,
  input wire logic [timer_capture_pkg::NUM_CH-1:0] channel_pin_in,
  output logic [timer_capture_pkg::NUM_CH-1:0] channel_pin_out,
  output logic [timer_capture_pkg::NUM_CH-1:0] channel_pin_oe,
  input wire logic lowspeed_osc_trigger,
  input wire logic external_count_clock_pin,
  input wire logic fast_osc_clock,
  input wire logic fast_osc_divided_clock,
  output logic [timer_capture_pkg::NUM_CH-1:0] capture_irq,
  output logic overflow_irq
);
  import timer_capture_pkg::*;

  typedef struct packed {
    logic ap_valid;
    logic ap_write;
    logic [9:0] ap_idx;
    logic [DATA_W-1:0] hrdata;
    logic hreadyout;
    logic [7:0] mode;
    logic [7:0] ctrl1;
    logic [7:0] cap_ab;
    logic [7:0] cap_cd;
    logic [7:0] filter;
    logic [7:0] port;
    logic [7:0] status;
    logic [4:0] prescale;
    logic [CNT_W-1:0] count;
    logic [NUM_CH-1:0][CNT_W-1:0] gr;
    logic [NUM_CH-1:0] cap_irq;
    logic ovf_irq;
    logic [NUM_CH-1:0] pin_out;
    logic [NUM_CH-1:0] pin_oe;
  } timer_t;

  localparam timer_t RESET_STATE = '{
    ap_valid: 1'b0, ap_write: 1'b0, ap_idx: 10'h000, hrdata: 32'h0000_0000,
    hreadyout: 1'b1, mode: RST_MODE, ctrl1: RST_CTRL1, cap_ab: RST_CAP_AB,
    cap_cd: RST_CAP_CD, filter: RST_FILTER, port: RST_PORT, status: 8'h00,
    prescale: 5'h00, count: 16'h0000, gr: '0, cap_irq: 4'h0, ovf_irq: 1'b0,
    pin_out: 4'h0, pin_oe: 4'h0};

  timer_t st_r;
  timer_t st_nxt;

  logic [NUM_IN-1:0] raw_in;
  logic [NUM_IN-1:0] ev;
  logic [NUM_IN-1:0][1:0] edge_sel;
  logic [NUM_IN-1:0] filt_en;
  logic [NUM_CH-1:0] mode_sel;
  logic [NUM_CH-1:0] pin_ev;
  logic trig_a;
  logic trig_b;
  logic buf_c;
  logic buf_d;
  logic tick;
  logic wr;

  assign raw_in = {fast_osc_divided_clock, fast_osc_clock, external_count_clock_pin,
                   lowspeed_osc_trigger, channel_pin_in};
  assign mode_sel = {st_r.cap_cd[MODE_SEL_HIGH], st_r.cap_cd[MODE_SEL_LOW],
                     st_r.cap_ab[MODE_SEL_HIGH], st_r.cap_ab[MODE_SEL_LOW]};

  always_comb begin
    edge_sel[0] = st_r.cap_ab[EDGE_LO_LOW +: 2];
    edge_sel[1] = st_r.cap_ab[EDGE_HI_LOW +: 2];
    edge_sel[2] = st_r.cap_cd[EDGE_LO_LOW +: 2];
    edge_sel[3] = st_r.cap_cd[EDGE_HI_LOW +: 2];
    // The oscillator trigger stands in for pin A and follows its edge field.
    edge_sel[4] = st_r.cap_ab[EDGE_LO_LOW +: 2];
    edge_sel[5] = EDGE_RISE;
    edge_sel[6] = EDGE_RISE;
    edge_sel[7] = EDGE_RISE;
    filt_en = {4'h0, st_r.filter[NUM_CH-1:0]};
  end

  // Clock-rate inputs are sampled at 20 MHz, so a source faster than half
  // that rate loses counts; that is a known limit of sampling them here.
  for (genvar i = 0; i < NUM_IN; i++) begin : g_in
    capture_input_conditioner u_cond (
      .clk(clk),
      .sys_rst(sys_rst),
      .sig_in(raw_in[i]),
      .filter_en(filt_en[i]),
      .edge_sel(edge_sel[i]),
      .evt(ev[i])
    );
  end

  always_comb begin
    pin_ev = ev[NUM_CH-1:0] & mode_sel;
    // Trigger source only matters while channel A is in capture mode.
    trig_a = mode_sel[0] && (st_r.cap_ab[TRIG_SRC_A] ? ev[0] : ev[4]);
    trig_b = pin_ev[1];
    buf_c = st_r.mode[MODE_BUF_C];
    buf_d = st_r.mode[MODE_BUF_D];
    unique case (st_r.ctrl1[CTRL1_SRC_LO +: 3])
      SRC_DIV1: tick = 1'b1;
      SRC_DIV2: tick = st_r.prescale[0];
      SRC_DIV4: tick = &st_r.prescale[1:0];
      SRC_DIV8: tick = &st_r.prescale[2:0];
      SRC_DIV32: tick = &st_r.prescale;
      SRC_EXT: tick = ev[5];
      SRC_FAST: tick = ev[6];
      SRC_FAST_DIV: tick = ev[7];
    endcase
    wr = st_r.ap_valid && st_r.ap_write;
  end

  always_comb begin
    logic [7:0] set;
    logic [7:0] clr;
    set = 8'h00;
    clr = 8'h00;
    st_nxt = st_r;
    st_nxt.hreadyout = 1'b1;
    st_nxt.ap_valid = hsel && htrans[1] && hready;
    st_nxt.ap_write = hwrite;
    st_nxt.ap_idx = haddr[11:2];
    // The prescaler free-runs from reset, so the first divided tick after a start
    // can come up to one source period early.
    st_nxt.prescale = st_r.prescale + 5'h01;

    // Read data is fetched in the address phase so it stands in the data phase.
    // A read right behind a write to the same register returns the value held
    // before that write, since the decode looks at the registered state.
    st_nxt.hrdata = '0;
    if (hsel && htrans[1] && hready && !hwrite) begin
      unique case (haddr[11:2])
        IDX_MODE: st_nxt.hrdata[7:0] = st_r.mode;
        IDX_CTRL1: st_nxt.hrdata[7:0] = st_r.ctrl1;
        IDX_CAP_AB: st_nxt.hrdata[7:0] = st_r.cap_ab | CAP_AB_FIXED;
        IDX_CAP_CD: st_nxt.hrdata[7:0] = st_r.cap_cd;
        IDX_COUNT: st_nxt.hrdata[CNT_W-1:0] = st_r.count;
        IDX_GRA: st_nxt.hrdata[CNT_W-1:0] = st_r.gr[0];
        IDX_GRB: st_nxt.hrdata[CNT_W-1:0] = st_r.gr[1];
        IDX_GRC: st_nxt.hrdata[CNT_W-1:0] = st_r.gr[2];
        IDX_GRD: st_nxt.hrdata[CNT_W-1:0] = st_r.gr[3];
        IDX_FILTER: st_nxt.hrdata[7:0] = st_r.filter;
        IDX_STATUS: st_nxt.hrdata[7:0] = st_r.status;
        IDX_PORT: st_nxt.hrdata[7:0] = st_r.port;
        default: st_nxt.hrdata = '0;
      endcase
    end

    if (wr) begin
      unique case (st_r.ap_idx)
        IDX_MODE: st_nxt.mode = hwdata[7:0] & MODE_WMASK;
        IDX_CTRL1: st_nxt.ctrl1 = hwdata[7:0];
        IDX_CAP_AB: st_nxt.cap_ab = hwdata[7:0] | CAP_AB_FIXED;
        IDX_CAP_CD: st_nxt.cap_cd = hwdata[7:0];
        IDX_GRA: st_nxt.gr[0] = hwdata[CNT_W-1:0];
        IDX_GRB: st_nxt.gr[1] = hwdata[CNT_W-1:0];
        IDX_GRC: st_nxt.gr[2] = hwdata[CNT_W-1:0];
        IDX_GRD: st_nxt.gr[3] = hwdata[CNT_W-1:0];
        IDX_FILTER: st_nxt.filter = hwdata[7:0];
        IDX_STATUS: clr = hwdata[7:0];
        IDX_PORT: st_nxt.port = hwdata[7:0];
        default: st_nxt.mode = st_r.mode;
      endcase
    end

    // A software write to the counter beats clearing and counting.
    if (wr && st_r.ap_idx == IDX_COUNT) begin
      st_nxt.count = hwdata[CNT_W-1:0];
    end else if (st_r.ctrl1[CTRL1_CLEAR] && trig_a) begin
      st_nxt.count = '0;
    end else if (st_r.mode[MODE_START] && tick) begin
      st_nxt.count = st_r.count + 16'h0001;
      if (st_r.count == CNT_MAX) begin
        set[ST_OVF] = 1'b1;
      end
    end

    // Captures win over software writes of the same general register.
    if (trig_a) begin
      st_nxt.gr[0] = st_r.count;
      set[0] = 1'b1;
      if (buf_c) begin
        st_nxt.gr[2] = st_r.gr[0];
      end
    end
    if (trig_b) begin
      st_nxt.gr[1] = st_r.count;
      set[1] = 1'b1;
      if (buf_d) begin
        st_nxt.gr[3] = st_r.gr[1];
      end
    end
    if (pin_ev[2]) begin
      set[2] = 1'b1;
      if (!buf_c) begin
        st_nxt.gr[2] = st_r.count;
      end
    end
    if (pin_ev[3]) begin
      set[3] = 1'b1;
      if (!buf_d) begin
        st_nxt.gr[3] = st_r.count;
      end
    end

    // A flag set in the cycle it is cleared stays set.
    st_nxt.status = (st_r.status & ~clr) | set;
    st_nxt.cap_irq = set[NUM_CH-1:0];
    st_nxt.ovf_irq = set[ST_OVF];
    st_nxt.pin_out = st_r.port[NUM_CH-1:0];
    st_nxt.pin_oe = st_r.port[PORT_DIR_LO +: NUM_CH] & ~mode_sel;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= RESET_STATE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hreadyout = st_r.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = st_r.hrdata;
  assign channel_pin_out = st_r.pin_out;
  assign channel_pin_oe = st_r.pin_oe;
  assign capture_irq = st_r.cap_irq;
  assign overflow_irq = st_r.ovf_irq;

  AST_CAPTURE_A: assert property (@(posedge clk) disable iff (sys_rst)
    trig_a && !(wr && st_r.ap_idx == IDX_GRA) |=> st_r.gr[0] == $past(st_r.count))
    else $error("channel A capture did not store the counter");
  AST_BUFFER_A: assert property (@(posedge clk) disable iff (sys_rst)
    trig_a && buf_c |=> st_r.gr[2] == $past(st_r.gr[0]))
    else $error("buffer C did not take the old A value");
  AST_WRAP: assert property (@(posedge clk) disable iff (sys_rst)
    st_r.mode[MODE_START] && tick && st_r.count == CNT_MAX && !wr && !trig_a
    |=> st_r.count == 16'h0000 && overflow_irq && st_r.status[ST_OVF])
    else $error("counter wrap did not signal overflow");
  AST_INCREMENT: assert property (@(posedge clk) disable iff (sys_rst)
    st_r.mode[MODE_START] && tick && !wr && !trig_a
    |=> st_r.count == $past(st_r.count) + 16'h0001)
    else $error("counter did not advance on a tick");
  AST_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    !st_r.mode[MODE_START] && !wr && !(st_r.ctrl1[CTRL1_CLEAR] && trig_a)
    |=> $stable(st_r.count))
    else $error("stopped counter changed");
  AST_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
    st_r.ctrl1[CTRL1_CLEAR] && trig_a && !wr |=> st_r.count == 16'h0000)
    else $error("counter not cleared on channel A capture");
  AST_BIT7: assert property (@(posedge clk) disable iff (sys_rst)
    hsel && htrans[1] && hready && !hwrite && haddr[11:2] == IDX_CAP_AB |=> hrdata[7])
    else $error("capture control bit 7 read as zero");
  AST_RESET_AB: assert property (@(posedge clk)
    $past(sys_rst) && !sys_rst |-> st_r.cap_ab == 8'h88)
    else $error("capture control reset value wrong");
  AST_IRQ: assert property (@(posedge clk) disable iff (sys_rst)
    pin_ev[1] |=> capture_irq[1] ##1 !capture_irq[1] || $past(pin_ev[1]))
    else $error("capture request missing or stretched");
  AST_PIN_MODE: assert property (@(posedge clk) disable iff (sys_rst)
    mode_sel[0] |=> !channel_pin_oe[0])
    else $error("capture pin still driven");
  AST_OWN_FLAG: assert property (@(posedge clk) disable iff (sys_rst)
    pin_ev[2] && buf_c |=> st_r.status[2] && $stable(st_r.gr[2]) || $past(trig_a))
    else $error("buffer channel flag not set by its own pin");

  // Per-channel capture, buffering and control-bit checks, plus counter write and overflow pulse checks.
  AST_CAPTURE_B: assert property (@(posedge clk) disable iff (sys_rst)
    trig_b |=> st_r.gr[1] == $past(st_r.count))
    else $error("channel B capture did not store the counter");
  AST_CAPTURE_C: assert property (@(posedge clk) disable iff (sys_rst)
    pin_ev[2] && !buf_c |=> st_r.gr[2] == $past(st_r.count))
    else $error("channel C did not capture from its own pin");
  AST_CAPTURE_D: assert property (@(posedge clk) disable iff (sys_rst)
    pin_ev[3] && !buf_d |=> st_r.gr[3] == $past(st_r.count))
    else $error("channel D did not capture from its own pin");
  AST_BUFFER_B: assert property (@(posedge clk) disable iff (sys_rst)
    trig_b && buf_d |=> st_r.gr[3] == $past(st_r.gr[1]))
    else $error("buffer D did not take the old B value");
  AST_FLAG_D: assert property (@(posedge clk) disable iff (sys_rst)
    pin_ev[3] |=> st_r.status[3] && capture_irq[3])
    else $error("channel D flag or request missing after its pin edge");
  AST_START: assert property (@(posedge clk) disable iff (sys_rst)
    wr && st_r.ap_idx == IDX_MODE && hwdata[MODE_START] |=> st_r.mode[MODE_START])
    else $error("start bit write did not start the counter");
  AST_STOP: assert property (@(posedge clk) disable iff (sys_rst)
    wr && st_r.ap_idx == IDX_MODE && !hwdata[MODE_START] |=> !st_r.mode[MODE_START])
    else $error("start bit clear did not stop the counter");
  AST_COUNT_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
    wr && st_r.ap_idx == IDX_COUNT |=> st_r.count == $past(hwdata[CNT_W-1:0]))
    else $error("counter write did not load the counter");
  AST_EDGE_RESERVED: assert property (@(posedge clk) disable iff (sys_rst)
    edge_sel[1] == 2'h3 |=> !ev[1])
    else $error("reserved edge select produced an event");
  AST_TRIG_SOURCE: assert property (@(posedge clk) disable iff (sys_rst)
    mode_sel[0] && !st_r.cap_ab[TRIG_SRC_A] && ev[0] && !ev[4] |=> !capture_irq[0])
    else $error("pin A captured while the oscillator trigger was selected");
  AST_PORT_MODE_A: assert property (@(posedge clk) disable iff (sys_rst)
    !mode_sel[0] |=> !capture_irq[0])
    else $error("channel A captured outside capture mode");
  AST_PORT_DRIVE: assert property (@(posedge clk) disable iff (sys_rst)
    !mode_sel[0] && st_r.port[PORT_DIR_LO] |=> channel_pin_oe[0])
    else $error("port pin A not driven as output");
  AST_OVF_PULSE: assert property (@(posedge clk) disable iff (sys_rst)
    overflow_irq |=> !overflow_irq)
    else $error("overflow request stretched");
endmodule : timer_input_capture
`default_nettype wire

// ===== bench/signal_source.sv
/*
  Far-side model: levels on the four capture pins, the low-speed trigger and three
  count-clock lines (external pin, fast clock, divided fast clock).
  Assumes the bench merges the pin levels with the block's output enables.
*/
`default_nettype none
module signal_source (
  input wire logic clk,
  output logic [3:0] pin_drv,
  output logic lso_trig,
  output logic [2:0] cnt_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    pin_drv = 4'h0;
    lso_trig = 1'b0;
    cnt_clk = 3'h0;
  end
  // Each level stands six clocks, well clear of the three-clock minimum edge spacing.
  task automatic set_pin(input int ch, input logic lvl);
    @(posedge clk);
    pin_drv[ch] <= lvl;
    repeat (6) @(posedge clk);
  endtask : set_pin
  // A one-clock pulse, shorter than the filter's three matching samples.
  task automatic glitch(input int ch);
    @(posedge clk);
    pin_drv[ch] <= 1'b1;
    @(posedge clk);
    pin_drv[ch] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : glitch
  task automatic pulse_lso();
    @(posedge clk);
    lso_trig <= 1'b1;
    repeat (6) @(posedge clk);
    lso_trig <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : pulse_lso
  // Count clocks stand low between bursts; a high phase lasts three clocks.
  task automatic clk_pulses(input int line, input int n);
    repeat (n) begin
      @(posedge clk);
      cnt_clk[line] <= 1'b1;
      repeat (3) @(posedge clk);
      cnt_clk[line] <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask : clk_pulses
endmodule : signal_source
`default_nettype wire

// ===== bench/timer_input_capture_tb.sv
/*
  Self-checking bench for the input-capture timer: AHB-Lite master tasks, one task
  per scenario. Assumes zero-wait-state slave and the signal_source far-side model.
*/
`default_nettype none
module timer_input_capture_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import timer_capture_pkg::*;
  logic clk, sys_rst, hsel, hwrite, hreadyout, hresp, overflow_irq, lso;
  logic [1:0] htrans;
  logic [2:0] hsize, cclk;
  logic [ADDR_W-1:0] haddr;
  logic [DATA_W-1:0] hwdata, hrdata;
  logic [3:0] pin_out, pin_oe, pin_drv, pin_w, capture_irq;
  int n_fail, checks, cyc, ovf_n;
  int irq_n[4];
  // Pins resolve to the block's drive where enabled, else the far side's level.
  assign pin_w = (pin_oe & pin_out) | (~pin_oe & pin_drv);
  timer_input_capture timer_input_capture_inst (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .channel_pin_in(pin_w), .channel_pin_out(pin_out), .channel_pin_oe(pin_oe),
    .lowspeed_osc_trigger(lso), .external_count_clock_pin(cclk[0]),
    .fast_osc_clock(cclk[1]), .fast_osc_divided_clock(cclk[2]),
    .capture_irq(capture_irq), .overflow_irq(overflow_irq));
  signal_source signal_source_inst (.clk(clk), .pin_drv(pin_drv), .lso_trig(lso),
    .cnt_clk(cclk));
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (sys_rst === 1'b0) begin
      for (int i = 0; i < 4; i++) if (capture_irq[i] === 1'b1) irq_n[i]++;
      if (overflow_irq === 1'b1) ovf_n++;
    end
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic bus(input logic [9:0] idx, input logic we, input logic [31:0] wd,
                     output logic [31:0] rdat);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {20'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= we;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask : bus
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic chk_rng(input logic [31:0] got, input int lo, input int hi, input string what);
    checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t %s: got %h outside %0d..%0d", $time, what, got, lo, hi);
    end
  endtask : chk_rng
  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] unused;
    bus(idx, 1'b1, d, unused);
  endtask : wr
  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    bus(idx, 1'b0, 32'h0, d);
    chk(d, exp, "register read");
  endtask : rd
  task automatic t_reset();
    rd(IDX_CAP_AB, 32'h88);
    chk({31'h0, hresp}, 32'h0, "response code");
    rd(IDX_CAP_CD, 32'h0);
    rd(IDX_COUNT, 32'h0);
    rd(10'h3ff, 32'h0);
    wr(IDX_CAP_AB, 32'h0);
    rd(IDX_CAP_AB, 32'h80);
    wr(IDX_COUNT, 32'hbeef);
    rd(IDX_COUNT, 32'hbeef);
    $display("test reset done");
  endtask : t_reset
  task automatic t_sources();
    logic [31:0] a, b;
    int k;
    for (int s = 0; s < 8; s++) begin
      wr(IDX_CTRL1, 32'(s) << CTRL1_SRC_LO);
      wr(IDX_COUNT, 32'h0);
      wr(IDX_MODE, 32'h1);
      if (s < 5) repeat (64) @(posedge clk);
      else signal_source_inst.clk_pulses(s - 5, 5);
      wr(IDX_MODE, 32'h0);
      bus(IDX_COUNT, 1'b0, 32'h0, a);
      repeat (8) @(posedge clk);
      bus(IDX_COUNT, 1'b0, 32'h0, b);
      chk(b, a, "count held after stop");
      k = (s == 4) ? 32 : (1 << s);
      if (s < 5) chk_rng(a, 60 / k, 70 / k + 1, "divided count");
      else chk_rng(a, 5, 5, "edge count");
    end
    $display("test sources done");
  endtask : t_sources
  task automatic t_overflow();
    logic [31:0] a;
    int base;
    wr(IDX_CTRL1, 32'h0);
    wr(IDX_COUNT, 32'hfff0);
    base = ovf_n;
    wr(IDX_MODE, 32'h1);
    repeat (40) @(posedge clk);
    wr(IDX_MODE, 32'h0);
    chk(32'(ovf_n - base), 32'h1, "overflow pulses");
    bus(IDX_COUNT, 1'b0, 32'h0, a);
    chk_rng(a, 20, 35, "count after wrap");
    $display("test overflow done");
  endtask : t_overflow
  task automatic t_edges();
    logic [1:0] s;
    logic [7:0] f;
    logic [31:0] v;
    int base, n;
    for (int ch = 0; ch < 4; ch++) begin
      for (int e = 0; e < 4; e++) begin
        s = 2'(e);
        v = 32'h1000 + 32'(ch * 16 + e);
        // Software selects capture mode, pin trigger and register function bits.
        if (ch[0] == 1'b0) f = {4'h0, 2'b11, s};
        else f = {ch == 3, 1'b1, s, (ch == 1) ? 4'h8 : 4'h0};
        wr(IDX_COUNT, v);
        wr((ch < 2) ? IDX_CAP_AB : IDX_CAP_CD, {24'h0, f});
        base = irq_n[ch];
        signal_source_inst.set_pin(ch, 1'b1);
        signal_source_inst.set_pin(ch, 1'b0);
        n = (e == 3) ? 0 : ((e == 2) ? 2 : 1);
        chk(32'(irq_n[ch] - base), 32'(n), "capture pulses");
        if (n > 0) rd(IDX_GRA + 10'(ch), v);
      end
    end
    $display("test edges done");
  endtask : t_edges
  task automatic t_trigger_port();
    int base;
    wr(IDX_COUNT, 32'h2222);
    wr(IDX_CAP_AB, 32'h04);
    base = irq_n[0];
    signal_source_inst.pulse_lso();
    signal_source_inst.set_pin(0, 1'b1);
    signal_source_inst.set_pin(0, 1'b0);
    chk(32'(irq_n[0] - base), 32'h1, "oscillator capture only");
    rd(IDX_GRA, 32'h2222);
    wr(IDX_CAP_AB, 32'h00);
    base = irq_n[0];
    signal_source_inst.pulse_lso();
    chk(32'(irq_n[0] - base), 32'h0, "no capture in port mode");
    wr(IDX_PORT, 32'h15);
    repeat (2) @(posedge clk);
    chk({28'h0, pin_oe}, 32'h1, "port drive enable");
    chk({31'h0, pin_out[0]}, 32'h1, "port output level");
    wr(IDX_CAP_AB, 32'h0c);
    repeat (2) @(posedge clk);
    chk({28'h0, pin_oe}, 32'h0, "capture pin released");
    wr(IDX_PORT, 32'h0);
    $display("test trigger and port done");
  endtask : t_trigger_port
  task automatic t_clear();
    logic [31:0] a;
    wr(IDX_CTRL1, 32'h80);
    wr(IDX_COUNT, 32'h5000);
    wr(IDX_MODE, 32'h1);
    repeat (10) @(posedge clk);
    signal_source_inst.set_pin(0, 1'b1);
    wr(IDX_MODE, 32'h0);
    bus(IDX_COUNT, 1'b0, 32'h0, a);
    chk_rng(a, 0, 12, "count cleared by capture");
    bus(IDX_GRA, 1'b0, 32'h0, a);
    chk_rng(a, 32'h5008, 32'h5020, "captured before clear");
    signal_source_inst.set_pin(0, 1'b0);
    wr(IDX_CTRL1, 32'h0);
    $display("test clear done");
  endtask : t_clear
  task automatic t_buffer();
    wr(IDX_MODE, 32'h20);
    wr(IDX_CAP_AB, 32'h0c);
    wr(IDX_CAP_CD, 32'h0c);
    wr(IDX_COUNT, 32'h0aaa);
    signal_source_inst.set_pin(0, 1'b1);
    signal_source_inst.set_pin(0, 1'b0);
    wr(IDX_COUNT, 32'h0bbb);
    signal_source_inst.set_pin(0, 1'b1);
    signal_source_inst.set_pin(0, 1'b0);
    rd(IDX_GRA, 32'h0bbb);
    rd(IDX_GRC, 32'h0aaa);
    wr(IDX_STATUS, 32'h1f);
    signal_source_inst.set_pin(2, 1'b1);
    signal_source_inst.set_pin(2, 1'b0);
    rd(IDX_GRC, 32'h0aaa);
    rd(IDX_STATUS, 32'h04);
    wr(IDX_MODE, 32'h0);
    $display("test buffer done");
  endtask : t_buffer
  task automatic t_filter();
    int base;
    wr(IDX_CAP_AB, 32'h0c);
    wr(IDX_FILTER, 32'h1);
    base = irq_n[0];
    signal_source_inst.glitch(0);
    chk(32'(irq_n[0] - base), 32'h0, "glitch rejected by filter");
    signal_source_inst.set_pin(0, 1'b1);
    signal_source_inst.set_pin(0, 1'b0);
    chk(32'(irq_n[0] - base), 32'h1, "filtered capture");
    wr(IDX_FILTER, 32'h0);
    $display("test filter done");
  endtask : t_filter
  task automatic stop_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_sources();
    t_overflow();
    t_edges();
    t_trigger_port();
    t_clear();
    t_buffer();
    t_filter();
    stop_test();
  end
endmodule : timer_input_capture_tb
`default_nettype wire
